// [bench/drnb_bus_model.sv]
// system bus partner: grants on request, acks after a varying wait
`timescale 1ns/1ns
module drnb_bus_model
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic busReq,
  input wire logic busStb,
  input wire logic [23:0] busAddr,
  output logic busGrant,
  output logic busAck,
  output logic [15:0] busRdata
);
  logic [1:0] waitCnt;
  logic slow;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busGrant <= 1'b0;
      busAck <= 1'b0;
      waitCnt <= 2'h0;
      slow <= 1'b0;
      busRdata <= 16'h0f0f;
    end
    else
    begin
      busGrant <= busReq;
      // data not valid outside an answer, so it keeps toggling
      busRdata <= ~busRdata;
      if (busAck)
      begin
        busAck <= 1'b0;
        waitCnt <= 2'h0;
      end
      else if (busStb && busGrant && waitCnt == {slow, 1'b0})
      begin
        busAck <= 1'b1;
        slow <= ~slow;
        busRdata <= busAddr[15:0] ^ 16'ha5c3;
      end
      else if (busStb && busGrant)
        waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule

// [bench/drnb_dmac_assertions.sv]
// concurrent checks on the dma pair top-level ports
`timescale 1ns/1ns
module drnb_dmac_assertions
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busGrant,
  input wire logic busAck,
  input wire logic busReq,
  input wire logic busStb,
  input wire logic busWrite,
  input wire logic [23:0] busAddr,
  input wire logic cpuIrq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_after: assert property (
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  // ---------------------------------------------------------------
  // system bus and completion
  // ---------------------------------------------------------------
  a_stb_hold: assert property (
    busStb && !(busAck && busGrant)
    |=> busStb && $stable(busAddr) && $stable(busWrite))
    else $error("bus cycle changed before acknowledge");
  a_stb_req: assert property (busStb |-> busReq)
    else $error("bus cycle without bus request");
  a_irq_pulse: assert property (cpuIrq |=> !cpuIrq)
    else $error("interrupt longer than one cycle");
  a_irq_cause: assert property (
    cpuIrq |-> $past(busAck && busGrant && busWrite))
    else $error("interrupt not after a write acknowledge");
endmodule

bind drnb_dmac drnb_dmac_assertions u_chk (.clk_sys, .nrst, .psel, .penable,
  .prdata, .pready, .pslverr, .busGrant, .busAck, .busReq, .busStb, .busWrite,
  .busAddr, .cpuIrq);

// [bench/testbench.sv]
// bench: register access, repeat, normal and block mode scenarios
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic pready, pslverr, busGrant, busAck, busReq, busStb, busWrite, cpuIrq;
  logic [3:0] timerMatch = 4'h0;
  logic serTxEmpty = 1'b0, serRxFull = 1'b0, dreq_n = 1'b1, busHold = 1'b0;
  logic [15:0] busRdata, busWdata;
  logic [23:0] busAddr;
  logic [23:0] wa[0:31], ra[0:31];
  logic [15:0] wd[0:31];
  logic e, done, busSize, sz, lastReq = 1'b0;
  int nw = 0, nr = 0, irqs = 0, err_total = 0, check_count = 0;
  int reqUp = 0, q = 0;
  always #5 clk_sys = ~clk_sys;
  drnb_dmac u_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timerMatch, .serTxEmpty,
    .serRxFull, .dreq_n, .busGrant, .busAck, .busHold, .busRdata, .busReq,
    .busStb, .busWrite, .busSize, .busAddr, .busWdata, .cpuIrq);
  drnb_bus_model u_bus (.clk_sys, .nrst, .busReq, .busStb, .busAddr,
    .busGrant, .busAck, .busRdata);
  // ---------------------------------------------------------------
  // bus monitor
  // ---------------------------------------------------------------
  assign done = busStb === 1'b1 && busAck === 1'b1 && busGrant === 1'b1;
  always @(posedge clk_sys)
  begin
    if (cpuIrq === 1'b1) irqs <= irqs + 1;
    if (done && busWrite === 1'b1) wa[nw] <= busAddr;
    if (done && busWrite === 1'b1) wd[nw] <= busWdata;
    if (done && busWrite === 1'b1) nw <= nw + 1;
    if (done && busWrite === 1'b0) ra[nr] <= busAddr;
    if (done && busWrite === 1'b0) nr <= nr + 1;
    if (done) sz <= busSize;
    lastReq <= busReq;
    if (busReq === 1'b1 && lastReq === 1'b0) reqUp <= reqUp + 1;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) chk("apb ready", 32'h0, 32'h1);
    if (i == 20) report_and_stop;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, r, exp);
  endtask
  task waitw(input int n);
    for (int i = 0; i < 400 && nw < n; i++) @(posedge clk_sys);
    chk("bus writes", 32'(nw), 32'(n));
    if (nw < n) report_and_stop;
  endtask
  // k 0-3 timers, 4 transmit empty, 5 receive full
  task pulse(input int k);
    @(posedge clk_sys);
    {serRxFull, serTxEmpty, timerMatch} <= 6'h01 << k;
    @(posedge clk_sys);
    {serRxFull, serTxEmpty, timerMatch} <= 6'h00;
  endtask
  // low long enough to pass the synchroniser and edge detect
  task fall;
    @(posedge clk_sys);
    dreq_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    dreq_n <= 1'b1;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h0c, 32'h0, "ctrl a reset");
    rd(8'h14, 32'h0, "iolow b reset");
    rd(8'h40, 32'h0, "unmapped data");
    chk("unmapped error", {31'h0, e}, 32'h1);
    // repeat mode on channel a: word, up, timer 0, count 2
    apb(1'b1, 8'h04, 32'h34);
    apb(1'b1, 8'h00, 32'h100);
    apb(1'b1, 8'h08, 32'h0202);
    apb(1'b1, 8'h0c, 32'h005);
    pulse(0);
    waitw(1);
    pulse(0);
    waitw(2);
    chk("first read", ra[0], 24'h000100);
    chk("second read", ra[1], 24'h000102);
    chk("io address", wa[0], 24'hffff34);
    chk("io address held", wa[1], 24'hffff34);
    chk("io data", wd[1], 16'h0102 ^ 16'ha5c3);
    rd(8'h00, 32'h100, "pointer restored");
    rd(8'h08, 32'h0202, "count reloaded");
    pulse(1);
    repeat (40) @(posedge clk_sys);
    chk("unselected timer", 32'(nw), 32'h2);
    // pause and resume
    apb(1'b1, 8'h0c, 32'h004);
    pulse(0);
    repeat (40) @(posedge clk_sys);
    chk("paused", 32'(nw), 32'h2);
    apb(1'b1, 8'h0c, 32'h005);
    pulse(0);
    waitw(3);
    chk("resumed read", ra[2], 24'h000100);
    chk("word unit", {31'h0, sz}, 32'h1);
    rd(8'h08, 32'h0102, "count after resume");
    chk("no repeat irq", 32'(irqs), 32'h0);
    // channel b repeat, byte, receive full: peripheral to memory
    apb(1'b1, 8'h14, 32'h56);
    apb(1'b1, 8'h10, 32'h400);
    apb(1'b1, 8'h18, 32'h0303);
    apb(1'b1, 8'h1c, 32'h281);
    pulse(5);
    waitw(4);
    chk("rx source", ra[3], 24'hffff56);
    chk("rx dest", wa[3], 24'h000400);
    chk("byte unit", {31'h0, sz}, 32'h0);
    rd(8'h10, 32'h401, "byte step");
    rd(8'h18, 32'h0203, "b count");
    rd(8'h00, 32'h102, "a untouched");
    // normal mode auto request, word, three transfers, cycle steal
    q = reqUp;
    apb(1'b1, 8'h10, 32'h3000);
    apb(1'b1, 8'h00, 32'h2000);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h0c, 32'h787);
    waitw(7);
    repeat (10) @(posedge clk_sys);
    chk("normal source", ra[6], 24'h002004);
    chk("normal dest", wa[6], 24'h003004);
    chk("normal data", wd[6], 16'h2004 ^ 16'ha5c3);
    chk("steal releases", 32'(reqUp - q), 32'h3);
    chk("normal irq", 32'(irqs), 32'h1);
    rd(8'h08, 32'h0, "normal count");
    rd(8'h0c, 32'h786, "enable cleared");
    chk("no extra", 32'(nw), 32'h7);
    // normal burst, two transfers on one bus request
    q = reqUp;
    apb(1'b1, 8'h00, 32'h2100);
    apb(1'b1, 8'h10, 32'h3100);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h0c, 32'h7a7);
    waitw(9);
    repeat (10) @(posedge clk_sys);
    chk("burst dest", wa[8], 24'h003102);
    chk("burst one request", 32'(reqUp - q), 32'h1);
    chk("burst irq", 32'(irqs), 32'h2);
    // block mode, byte, source is the area, two blocks of two
    apb(1'b1, 8'h00, 32'h5000);
    apb(1'b1, 8'h10, 32'h6000);
    apb(1'b1, 8'h08, 32'h0202);
    apb(1'b1, 8'h18, 32'h2);
    apb(1'b1, 8'h1c, 32'h040);
    apb(1'b1, 8'h0c, 32'ha83);
    pulse(5);
    repeat (40) @(posedge clk_sys);
    chk("block rx refused", 32'(nw), 32'h9);
    apb(1'b1, 8'h0c, 32'hb03);
    q = reqUp;
    fall;
    waitw(11);
    repeat (40) @(posedge clk_sys);
    chk("block waits", 32'(nw), 32'hb);
    chk("block one request", 32'(reqUp - q), 32'h1);
    rd(8'h00, 32'h5000, "area restored");
    rd(8'h10, 32'h6002, "dest advanced");
    rd(8'h08, 32'h0202, "size reloaded");
    rd(8'h18, 32'h1, "block count");
    fall;
    waitw(13);
    repeat (10) @(posedge clk_sys);
    chk("area reread", ra[11], 24'h005000);
    chk("dest goes on", wa[12], 24'h006003);
    chk("block irq", 32'(irqs), 32'h3);
    rd(8'h0c, 32'hb02, "block enable cleared");
    report_and_stop;
  end
endmodule

// [logic/drnb_dmac.sv]
// dma channel pair: repeat, normal and block transfer modes
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// R1 - repeat mode chosen per channel independently; here the mode field of channel a sets it for both channels
// R2 - repeat: unit per request, wrap restores, continues
// R3 - receive-full trigger reads peripheral, others write it
// R4 - working counter decrements, reloads from initial count
// R5 - wrap restores pointer by signed size times count
// R6 - software loads both repeat counters equal
// R7 - repeat: no interrupt, pause and resume on enable
// R8 - peripheral address is ones above eight-bit register
// R9 - repeat count maximum 255 with all ones
// R10 - repeat triggers: timers, serial, external request
// R11 - normal: pair gives source, destination, own stepping
// R12 - normal: count to zero clears enable, interrupts
// R13 - normal count zero means 65536 transfers
// R14 - normal: external or auto request only
// R15 - cycle steal releases bus, burst holds it
// R16 - block: whole block per request, uninterrupted
// R17 - block end: reload size, restore area, count block
// R18 - block: wait per block, finish clears enable, interrupts
// R19 - area select: zero destination, one source
// R20 - software loads block size 1-255, count 1-65536
// R21 - block triggers: timers and external request only
// R22 - direction 0 up 1 down, size 0 byte 1 word
module drnb_dmac
#(
  parameter int ADDR_W = 24,
  parameter int CNT_W = 16
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] timerMatch,
  input wire logic serTxEmpty,
  input wire logic serRxFull,
  input wire logic dreq_n,
  input wire logic busGrant,
  input wire logic busAck,
  input wire logic busHold,
  input wire logic [15:0] busRdata,
  output logic busReq,
  output logic busStb,
  output logic busWrite,
  output logic busSize,
  output logic [23:0] busAddr,
  output logic [15:0] busWdata,
  output logic cpuIrq
);
  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  logic [ADDR_W-1:0] addr [2];
  logic [7:0] ioLow [2];
  logic [CNT_W-1:0] cnt [2];
  logic [drnb_pkg::CTRL_W-1:0] ctrl [2];
  logic [23:0] next_addr [2];
  logic [15:0] next_cnt [2];
  logic next_en [2];
  logic next_irq;
  logic next_keep;
  logic [1:0] pend;
  logic [2:0] dq;
  logic cur;
  logic keep;
  drnb_pkg::drnb_eng_e state;

  // -----------------------------------------------------------------
  // parameter check
  // -----------------------------------------------------------------
  // stepping, restore and the hi/lo counter split assume these widths
  generate
    if (ADDR_W != 24 || CNT_W != 16)
    begin
      $error("drnb_dmac serves only 24-bit addresses and 16-bit counts");
    end
  endgenerate

  wire [1:0] mode = ctrl[0][drnb_pkg::F_MODE_LO +: 2];
  wire pairMode = (mode != drnb_pkg::MODE_REPEAT);
  // -----------------------------------------------------------------
  // apb decode, one wait state
  // -----------------------------------------------------------------
  wire access = psel & penable & ~pready;
  wire [7:0] off = paddr[7:0];
  wire regCh = off[4];
  wire [7:0] regOff = off & 8'h0c;
  wire isStatus = (off == drnb_pkg::OFS_STATUS);
  wire mapped = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'h0)
    & ((off[7:5] == 3'h0) | isStatus);
  // a write lands at the edge that sees pready, when the master commits
  wire swWr = psel & penable & pready & pwrite & mapped & ~isStatus;
  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = 32'h00000000;
    if (isStatus)
      rdMux = {28'h0000000, (state != drnb_pkg::ENG_IDLE), cur, pend};
    else if (regOff == drnb_pkg::OFS_ADDR)
      rdMux = {8'h00, addr[regCh]};
    else if (regOff == drnb_pkg::OFS_IOLOW)
      rdMux = {24'h000000, ioLow[regCh]};
    else if (regOff == drnb_pkg::OFS_COUNT)
      rdMux = {16'h0000, cnt[regCh]};
    else
      rdMux = {20'h00000, ctrl[regCh]};
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= access;
      pslverr <= access & ~mapped;
      prdata <= (access & ~pwrite & mapped) ? rdMux : 32'h00000000;
    end
  end
  // -----------------------------------------------------------------
  // triggers
  // -----------------------------------------------------------------
  // two flops against metastability, the third only for the edge
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      dq <= 3'h7;
    else
      dq <= {dq[1:0], dreq_n};
  end
  wire dreqFall = dq[2] & ~dq[1];
  wire [7:0] ev = {1'b1, dreqFall, serRxFull, serTxEmpty, timerMatch};
  wire [2:0] sel0 = ctrl[0][drnb_pkg::F_SEL_LO +: 3];
  wire [2:0] sel1 = ctrl[1][drnb_pkg::F_SEL_LO +: 3];
  wire [7:0] legal0 = (mode == drnb_pkg::MODE_NORMAL) ? drnb_pkg::LEGAL_NORMAL
    : (mode == drnb_pkg::MODE_BLOCK) ? drnb_pkg::LEGAL_BLOCK
    : (mode == drnb_pkg::MODE_REPEAT) ? drnb_pkg::LEGAL_REPEAT
    : 8'h00; // see R10, R14, R21
  wire [7:0] legal1 = pairMode ? 8'h00 : drnb_pkg::LEGAL_REPEAT; // see R1
  wire en0 = ctrl[0][drnb_pkg::B_EN];
  wire en1 = ctrl[1][drnb_pkg::B_EN];
  wire [1:0] trig = {en1 & ev[sel1] & legal1[sel1],
    en0 & ev[sel0] & legal0[sel0]};
  // -----------------------------------------------------------------
  // channel pick and transfer addresses
  // -----------------------------------------------------------------
  wire go0 = pend[0] & en0;
  wire go1 = pend[1] & en1 & ~pairMode;
  wire start = (state == drnb_pkg::ENG_IDLE) & (go0 | go1);
  wire selc = (state == drnb_pkg::ENG_IDLE) ? ~go0 : cur;
  wire uc = pairMode ? 1'b0 : selc;
  wire [2:0] selU = uc ? sel1 : sel0;
  wire rx = (selU == drnb_pkg::SEL_RX_FULL);
  wire [23:0] ioAddr = {drnb_pkg::IO_HIGH, ioLow[uc]}; // see R8
  wire [23:0] srcAddr = pairMode ? addr[0]
    : (rx ? ioAddr : addr[uc]); // see R3, R11
  wire [23:0] dstAddr = pairMode ? addr[1] : (rx ? addr[uc] : ioAddr);
  wire usz = ctrl[uc][drnb_pkg::B_SIZE];
  wire [23:0] step = usz ? 24'h000002 : 24'h000001; // see R22
  wire [7:0] hi = cnt[uc][15:8];
  wire [7:0] lo = cnt[uc][7:0];
  wire [7:0] hiDec = hi - 8'h01; // see R4
  wire [23:0] delta = usz ? {15'h0000, lo, 1'b0} : {16'h0000, lo};

  function automatic logic [23:0] stepF(input logic [23:0] a,
    input logic dn, input logic hold, input logic [23:0] s);
    stepF = hold ? a : (dn ? a - s : a + s); // see R22
  endfunction

  // memory side moves back by the signed table length
  function automatic logic [23:0] restF(input logic [23:0] a,
    input logic dn, input logic hold, input logic [23:0] d);
    restF = hold ? a : (dn ? a + d : a - d); // see R5
  endfunction

  logic [23:0] aStep [2];
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      aStep[i] = stepF(addr[i], ctrl[i][drnb_pkg::B_DIR],
        pairMode & ctrl[i][drnb_pkg::B_HOLD], step); // see R11
  end
  // -----------------------------------------------------------------
  // end-of-unit update
  // -----------------------------------------------------------------
  // counters and pointers move only once the write side is acknowledged
  wire unitDone = (state == drnb_pkg::ENG_WRITE) & busAck;
  wire areaSide = ~ctrl[1][drnb_pkg::B_AREA_SRC]; // see R19
  wire [15:0] cnt0Dec = cnt[0] - 16'h0001;
  wire [15:0] cnt1Dec = cnt[1] - 16'h0001;
  always_comb
  begin
    next_addr[0] = addr[0];
    next_addr[1] = addr[1];
    next_cnt[0] = cnt[0];
    next_cnt[1] = cnt[1];
    next_en[0] = en0;
    next_en[1] = en1;
    next_irq = 1'b0;
    next_keep = 1'b0;
    case (mode)
      drnb_pkg::MODE_NORMAL:
      begin
        next_addr[0] = aStep[0];
        next_addr[1] = aStep[1];
        next_cnt[0] = cnt0Dec; // see R12, R13
        if (cnt0Dec == 16'h0000)
        begin
          next_en[0] = 1'b0; // see R12
          next_irq = ctrl[0][drnb_pkg::B_IE];
        end
        else
          next_keep = ctrl[0][drnb_pkg::B_BURST]
            & (sel0 == drnb_pkg::SEL_AUTO) & ~busHold; // see R14, R15
      end
      drnb_pkg::MODE_BLOCK:
      begin
        next_addr[0] = aStep[0];
        next_addr[1] = aStep[1];
        next_cnt[0][15:8] = hiDec;
        next_keep = 1'b1; // see R16
        if (hiDec == 8'h00)
        begin
          next_keep = 1'b0; // see R18
          next_cnt[0][15:8] = lo; // see R17
          next_addr[areaSide] = restF(aStep[areaSide],
            ctrl[areaSide][drnb_pkg::B_DIR],
            ctrl[areaSide][drnb_pkg::B_HOLD], delta); // see R17, R19
          next_cnt[1] = cnt1Dec; // see R17
          if (cnt1Dec == 16'h0000)
          begin
            next_en[0] = 1'b0; // see R18
            next_irq = ctrl[0][drnb_pkg::B_IE];
          end
        end
      end
      default:
      begin
        // repeat: never interrupts, enable left alone
        next_addr[uc] = (hiDec == 8'h00)
          ? restF(aStep[uc], ctrl[uc][drnb_pkg::B_DIR], 1'b0, delta)
          : aStep[uc]; // see R2, R5, R7
        next_cnt[uc][15:8] = (hiDec == 8'h00) ? lo : hiDec; // see R4, R9
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        addr[i] <= drnb_pkg::ADDR_RST;
        ioLow[i] <= drnb_pkg::IOLOW_RST;
        cnt[i] <= drnb_pkg::COUNT_RST;
        ctrl[i] <= drnb_pkg::CTRL_RST;
      end
    end
    else
    begin
      if (unitDone)
      begin
        for (int i = 0; i < 2; i++)
        begin
          addr[i] <= next_addr[i];
          cnt[i] <= next_cnt[i];
          ctrl[i][drnb_pkg::B_EN] <= next_en[i];
        end
      end
      // software write last, so it wins over the hardware update
      if (swWr)
      begin
        if (regOff == drnb_pkg::OFS_ADDR)
          addr[regCh] <= pwdata[23:0];
        else if (regOff == drnb_pkg::OFS_IOLOW)
          ioLow[regCh] <= pwdata[7:0];
        else if (regOff == drnb_pkg::OFS_COUNT)
          cnt[regCh] <= pwdata[15:0];
        else
          ctrl[regCh] <= pwdata[drnb_pkg::CTRL_W-1:0]; // see R7
      end
    end
  end
  // -----------------------------------------------------------------
  // transfer engine
  // -----------------------------------------------------------------
  // a request arriving while its flag is taken still sets it
  wire [1:0] clrPend = start ? (selc ? 2'h2 : 2'h1) : 2'h0;
  wire stillOn = pairMode ? en0 : (cur ? en1 : en0);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pend <= 2'h0;
    else
      pend <= trig | (pend & ~clrPend & {en1, en0}); // see R14
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= drnb_pkg::ENG_IDLE;
      cur <= 1'b0;
      keep <= 1'b0;
      busReq <= 1'b0;
      busStb <= 1'b0;
      busWrite <= 1'b0;
      busSize <= 1'b0;
      busAddr <= 24'h000000;
      busWdata <= 16'h0000;
      cpuIrq <= 1'b0;
    end
    else
    begin
      cpuIrq <= unitDone & next_irq; // see R12, R18
      case (state)
        drnb_pkg::ENG_IDLE:
          if (start)
          begin
            cur <= selc;
            busReq <= 1'b1;
            busStb <= 1'b1;
            busWrite <= 1'b0;
            busSize <= usz;
            busAddr <= srcAddr;
            state <= drnb_pkg::ENG_READ;
          end
        drnb_pkg::ENG_READ:
          if (busAck & busGrant)
          begin
            busWrite <= 1'b1;
            busAddr <= dstAddr;
            busWdata <= busRdata;
            state <= drnb_pkg::ENG_WRITE;
          end
        drnb_pkg::ENG_WRITE:
          if (busAck & busGrant)
          begin
            busStb <= 1'b0;
            busReq <= next_keep; // see R15
            keep <= next_keep;
            state <= drnb_pkg::ENG_NEXT;
          end
        drnb_pkg::ENG_NEXT:
          // registers have settled; continue the burst or let go
          if (keep & stillOn)
          begin
            busStb <= 1'b1;
            busWrite <= 1'b0;
            busAddr <= srcAddr;
            state <= drnb_pkg::ENG_READ; // see R16
          end
          else
          begin
            busReq <= 1'b0;
            state <= drnb_pkg::ENG_IDLE;
          end
        default:
          state <= drnb_pkg::ENG_IDLE;
      endcase
    end
  end
endmodule

// [logic/drnb_pkg.sv]
// constants, register map and state type of the dma channel pair
package drnb_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, channel b adds CH_STRIDE)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_IOLOW = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [7:0] IOLOW_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [11:0] CTRL_RST = 12'h000;
  // ---------------------------------------------------------------
  // channel_control_register fields
  // ---------------------------------------------------------------
  localparam int CTRL_W = 12;
  localparam int B_EN = 0;
  localparam int B_IE = 1;
  localparam int B_SIZE = 2;
  localparam int B_DIR = 3;
  localparam int B_HOLD = 4;
  localparam int B_BURST = 5;
  localparam int B_AREA_SRC = 6;
  localparam int F_SEL_LO = 7;
  localparam int F_MODE_LO = 10;
  // ---------------------------------------------------------------
  // modes, trigger selects and legal trigger masks
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_REPEAT = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;
  localparam logic [2:0] SEL_TX_EMPTY = 3'h4;
  localparam logic [2:0] SEL_RX_FULL = 3'h5;
  localparam logic [2:0] SEL_DREQ = 3'h6;
  localparam logic [2:0] SEL_AUTO = 3'h7;
  localparam logic [7:0] LEGAL_REPEAT = 8'h7f;
  localparam logic [7:0] LEGAL_NORMAL = 8'hc0;
  localparam logic [7:0] LEGAL_BLOCK = 8'h4f;
  localparam logic [15:0] IO_HIGH = 16'hffff;
  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE, ENG_NEXT}
    drnb_eng_e;
endpackage
